// File: verilog/fdc_pkg.sv
// Package: constants, register map and bus carriers of the duty path
package fdc_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          UPD_PERIOD_MS = 10;
  localparam int          UPD_CYCLES    = CLK_HZ / 1000 * UPD_PERIOD_MS;
  localparam int          AUX_LOW_US    = 100;
  localparam int          AUX_LOW_CYC   = CLK_HZ / 1_000_000 * AUX_LOW_US;
  localparam logic [11:0] CENTER        = 12'h800;
  localparam logic [11:0] SCALED_MAX    = 12'hfff;
  localparam logic [9:0]  DUTY_FULL     = 10'h258;
  localparam logic [4:0]  DIV_STEPS     = 5'h18;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_TARGET = 8'h04;
  localparam logic [7:0] A_FB_MIN = 8'h08;
  localparam logic [7:0] A_FB_MAX = 8'h0c;
  localparam logic [7:0] A_PROP   = 8'h10;
  localparam logic [7:0] A_MAXDUT = 8'h14;
  localparam logic [7:0] A_MAXACC = 8'h18;
  localparam logic [7:0] A_IRQSTS = 8'h1c;
  localparam logic [7:0] A_IRQMSK = 8'h20;
  localparam logic [7:0] A_RAW    = 8'h24;
  localparam logic [7:0] A_SCALED = 8'h28;
  localparam logic [7:0] A_ERROR  = 8'h2c;
  localparam logic [7:0] A_DCT    = 8'h30;
  localparam logic [7:0] A_DUTY   = 8'h34;
  // CTRL field positions
  localparam int C_FB_EN   = 0;
  localparam int C_FB_INV  = 1;
  localparam int C_MOT_INV = 2;
  localparam int C_DET_EN  = 3;
  // Interrupt bits
  localparam int I_UPDATE = 0;
  localparam int I_RANGE  = 1;
  // Reset values and AXI response codes
  localparam logic [3:0]  RST_CTRL   = 4'h0;
  localparam logic [11:0] RST_TARGET = 12'h800;
  localparam logic [11:0] RST_FB_MIN = 12'h000;
  localparam logic [11:0] RST_FB_MAX = 12'hfff;
  localparam logic [7:0]  RST_PROP   = 8'h00;
  localparam logic [9:0]  RST_MAXDUT = 10'h258;
  localparam logic [9:0]  RST_MAXACC = 10'h258;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fdc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fdc_axi_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_CALC, ST_LIMIT} fdc_st_t;
endpackage

// File: verilog/fdc_duty_path.sv
// Feedback scaling, proportional term and duty limiting with AXI4-Lite regs
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module fdc_duty_path
  import fdc_pkg::*;
#(
  parameter int UPD_CYC = UPD_CYCLES
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire fdc_axi_req_t axi_req,
  output fdc_axi_rsp_t      axi_rsp,
  input  wire logic [11:0]  analog_feedback_input,
  output logic [9:0]        motor_duty_mag,
  output logic              motor_dir,
  output logic              aux_power,
  output logic              irq
);

  typedef struct packed {
    fdc_st_t      st;
    logic [19:0]  cnt;
    logic [11:0]  sy1;
    logic [11:0]  sy2;
    logic [11:0]  sy3;
    logic [11:0]  fb_st;
    logic [4:0]   divn;
    logic [23:0]  num;
    logic [12:0]  rem;
    logic [23:0]  quo;
    logic         fb_hi;
    logic         fb_lo;
    logic [11:0]  w_raw;
    logic [11:0]  w_sc;
    logic [12:0]  w_err;
    logic [21:0]  w_dct;
    logic [3:0]   ctrl;
    logic [11:0]  target;
    logic [11:0]  fb_min;
    logic [11:0]  fb_max;
    logic [7:0]   prop;
    logic [9:0]   max_duty;
    logic [9:0]   max_acc;
    logic [1:0]   ists;
    logic [1:0]   imsk;
    logic [11:0]  raw;
    logic [11:0]  scaled;
    logic [12:0]  err;
    logic [21:0]  dct;
    logic [10:0]  duty;
    logic [9:0]   mag;
    logic         dir;
    logic         aux;
    logic         irq;
    logic         aw_h;
    logic [7:0]   awa;
    logic         w_h;
    logic [31:0]  wd;
    logic [3:0]   ws;
    fdc_axi_rsp_t rsp;
  } fdc_state_t;

  fdc_state_t q;
  fdc_state_t d;

  // Byte-lane merge for narrow registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign axi_rsp        = q.rsp;
  assign motor_duty_mag = q.mag;
  assign motor_dir      = q.dir;
  assign aux_power      = q.aux;
  assign irq            = q.irq;

  // Next state of the whole block
  always_comb begin
    logic               tick;
    logic [11:0]        diff;
    logic [12:0]        rem2;
    logic [11:0]        base;
    logic [11:0]        sc;
    logic signed [21:0] e22;
    logic signed [21:0] p22;
    logic signed [21:0] lim;
    logic signed [21:0] cur;
    logic signed [21:0] step;
    logic [31:0]        wv;
    logic [31:0]        rv;
    logic               rok;
    logic               wok;
    logic [1:0]         ev;
    tick = 1'b0;
    diff = 12'h000;
    rem2 = 13'h0000;
    base = 12'h000;
    sc   = 12'h000;
    e22  = 22'sh0;
    p22  = 22'sh0;
    lim  = 22'sh0;
    cur  = 22'sh0;
    step = 22'sh0;
    wv   = 32'h0;
    rv   = 32'h0;
    rok  = 1'b1;
    wok  = 1'b1;
    ev   = 2'h0;
    d    = q;

    // Feedback pin bus into a two-stage synchroniser
    d.sy1 = analog_feedback_input;
    d.sy2 = q.sy1;
    // Code bits may cross on different edges; keep a code only once it
    // stood for two cycles, so a torn word never reaches the math
    d.sy3 = q.sy2;
    if (q.sy2 == q.sy3) begin
      d.fb_st = q.sy2;
    end

    // Update period counter
    if (q.cnt == 20'(UPD_CYC - 1)) begin
      d.cnt = 20'h0;
      tick  = 1'b1;
    end else begin
      d.cnt = q.cnt + 20'h1;
    end

    // Aux power pulled low right after each tick, clear of the sample
    d.aux = !(q.ctrl[C_DET_EN] && q.cnt < 20'(AUX_LOW_CYC));

    // Update sequence: sample, divide, compute, limit
    unique case (q.st)
      ST_IDLE: begin
        if (tick) begin
          d.w_raw = q.fb_st;
          d.fb_hi = (q.fb_st > q.fb_max) ||
                    (q.fb_max <= q.fb_min && q.fb_st >= q.fb_max);
          d.fb_lo = q.fb_st < q.fb_min;
          diff    = q.fb_st - q.fb_min;
          // Times 4095 as shift minus one copy
          d.num   = {diff, 12'h000} - {12'h000, diff};
          d.rem   = 13'h0000;
          d.quo   = 24'h0;
          d.divn  = 5'h0;
          d.st    = ST_DIV;
          if (!q.ctrl[C_FB_EN] || d.fb_hi || d.fb_lo) begin
            d.st = ST_CALC;
          end
        end
      end
      ST_DIV: begin
        // One quotient bit a cycle keeps the divider small
        rem2  = {q.rem[11:0], q.num[23]};
        d.num = {q.num[22:0], 1'b0};
        if (rem2 >= {1'b0, q.fb_max - q.fb_min}) begin
          d.rem = rem2 - {1'b0, q.fb_max - q.fb_min};
          d.quo = {q.quo[22:0], 1'b1};
        end else begin
          d.rem = rem2;
          d.quo = {q.quo[22:0], 1'b0};
        end
        d.divn = q.divn + 5'h1;
        if (q.divn == DIV_STEPS - 5'h1) begin
          d.st = ST_CALC;
        end
      end
      ST_CALC: begin
        if (q.fb_hi) begin
          base = SCALED_MAX;
        end else if (q.fb_lo) begin
          base = 12'h000;
        end else begin
          base = q.quo[11:0];
        end
        sc = q.ctrl[C_FB_INV] ? ~base : base;
        if (q.ctrl[C_FB_EN]) begin
          d.w_sc  = sc;
          // Raw value never enters the error
          d.w_err = {1'b0, sc} - {1'b0, q.target};
          e22     = 22'(signed'(d.w_err));
          p22     = $signed({14'h0, q.prop});
          d.w_dct = -(e22 * p22);
        end else begin
          d.w_err = 13'h0000;
          d.w_dct = 22'({10'h0, q.target} - {10'h0, CENTER});
        end
        d.st = ST_LIMIT;
      end
      ST_LIMIT: begin
        // Max duty clamp, then acceleration step limit
        lim = $signed(q.w_dct);
        if (lim > $signed({12'h0, q.max_duty})) begin
          lim = $signed({12'h0, q.max_duty});
        end else if (lim < -$signed({12'h0, q.max_duty})) begin
          lim = -$signed({12'h0, q.max_duty});
        end
        cur  = 22'(signed'(q.duty));
        step = $signed({12'h0, q.max_acc});
        if (lim - cur > step) begin
          lim = cur + step;
        end else if (cur - lim > step) begin
          lim = cur - step;
        end
        // Publish every stage at once so software sees one snapshot
        d.raw    = q.w_raw;
        d.scaled = q.w_sc;
        d.err    = q.w_err;
        d.dct    = q.w_dct;
        d.duty   = lim[10:0];
        d.mag    = lim[21] ? 10'(-lim) : lim[9:0];
        d.dir    = lim[21] ^ q.ctrl[C_MOT_INV];
        ev[I_UPDATE] = 1'b1;
        ev[I_RANGE]  = q.ctrl[C_FB_EN] && (q.fb_hi || q.fb_lo);
        d.st = ST_IDLE;
      end
    endcase

    // Write address and data taken independently
    d.rsp.awready = 1'b0;
    d.rsp.wready  = 1'b0;
    if (!q.aw_h && q.rsp.awready && axi_req.awvalid) begin
      d.aw_h = 1'b1;
      d.awa  = axi_req.awaddr;
    end
    if (!q.w_h && q.rsp.wready && axi_req.wvalid) begin
      d.w_h = 1'b1;
      d.wd  = axi_req.wdata;
      d.ws  = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.aw_h && q.w_h && !q.rsp.bvalid) begin
      d.aw_h = 1'b0;
      d.w_h  = 1'b0;
      // Misaligned address falls to the refused default, no register hit
      unique case ((q.awa[1:0] == 2'h0) ? q.awa[7:2] : 6'h3f)
        A_CTRL[7:2]: begin
          wv     = merge({28'h0, q.ctrl}, q.wd, q.ws);
          d.ctrl = wv[3:0];
        end
        A_TARGET[7:2]: begin
          wv       = merge({20'h0, q.target}, q.wd, q.ws);
          d.target = wv[11:0];
        end
        A_FB_MIN[7:2]: begin
          wv       = merge({20'h0, q.fb_min}, q.wd, q.ws);
          d.fb_min = wv[11:0];
        end
        A_FB_MAX[7:2]: begin
          wv       = merge({20'h0, q.fb_max}, q.wd, q.ws);
          d.fb_max = wv[11:0];
        end
        A_PROP[7:2]: begin
          wv     = merge({24'h0, q.prop}, q.wd, q.ws);
          d.prop = wv[7:0];
        end
        A_MAXDUT[7:2]: begin
          wv = merge({22'h0, q.max_duty}, q.wd, q.ws);
          // Never beyond full scale
          d.max_duty = (wv[9:0] > DUTY_FULL) ? DUTY_FULL : wv[9:0];
        end
        A_MAXACC[7:2]: begin
          wv        = merge({22'h0, q.max_acc}, q.wd, q.ws);
          d.max_acc = wv[9:0];
        end
        A_IRQSTS[7:2]: begin
          wv     = merge(32'h0, q.wd, q.ws);
          d.ists = q.ists & ~wv[1:0];
        end
        A_IRQMSK[7:2]: begin
          wv     = merge({30'h0, q.imsk}, q.wd, q.ws);
          d.imsk = wv[1:0];
        end
        A_RAW[7:2], A_SCALED[7:2], A_ERROR[7:2],
        A_DCT[7:2], A_DUTY[7:2]: begin
          wok = 1'b1;
        end
        default: wok = 1'b0;
      endcase
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = (wok && q.awa[1:0] == 2'h0) ? RESP_OKAY
                                                  : RESP_SLVERR;
    end
    d.rsp.awready = !d.aw_h && !(q.rsp.awready && axi_req.awvalid);
    d.rsp.wready  = !d.w_h && !(q.rsp.wready && axi_req.wvalid);

    // Event set wins over a same-cycle clear
    d.ists = d.ists | ev;
    d.irq  = |(d.ists & d.imsk);

    // Read channel: answer one cycle after the address is taken
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (q.rsp.arready && axi_req.arvalid) begin
      // Misaligned read answers zero data with the error code
      unique case ((axi_req.araddr[1:0] == 2'h0) ? axi_req.araddr[7:2]
                                                  : 6'h3f)
        A_CTRL[7:2]:   rv = {28'h0, q.ctrl};
        A_TARGET[7:2]: rv = {20'h0, q.target};
        A_FB_MIN[7:2]: rv = {20'h0, q.fb_min};
        A_FB_MAX[7:2]: rv = {20'h0, q.fb_max};
        A_PROP[7:2]:   rv = {24'h0, q.prop};
        A_MAXDUT[7:2]: rv = {22'h0, q.max_duty};
        A_MAXACC[7:2]: rv = {22'h0, q.max_acc};
        A_IRQSTS[7:2]: rv = {30'h0, q.ists};
        A_IRQMSK[7:2]: rv = {30'h0, q.imsk};
        A_RAW[7:2]:    rv = {20'h0, q.raw};
        A_SCALED[7:2]: rv = {20'h0, q.scaled};
        A_ERROR[7:2]:  rv = {{19{q.err[12]}}, q.err};
        A_DCT[7:2]:    rv = {{10{q.dct[21]}}, q.dct};
        A_DUTY[7:2]:   rv = {{21{q.duty[10]}}, q.duty};
        default:       rok = 1'b0;
      endcase
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata  = rv;
      d.rsp.rresp  = (rok && axi_req.araddr[1:0] == 2'h0) ? RESP_OKAY
                                                           : RESP_SLVERR;
    end
    d.rsp.arready = !d.rsp.rvalid && !(q.rsp.arready && axi_req.arvalid);
  end

  // State register; reset gives stopped motor and open loop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.ctrl     <= RST_CTRL;
      q.target   <= RST_TARGET;
      q.fb_min   <= RST_FB_MIN;
      q.fb_max   <= RST_FB_MAX;
      q.prop     <= RST_PROP;
      q.max_duty <= RST_MAXDUT;
      q.max_acc  <= RST_MAXACC;
      q.aux      <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule

// File: bench/fdc_duty_path_assertions.sv
// Port-level assertions for the duty path, bound to its top module
`timescale 1ns/100ps
module fdc_duty_path_assertions
  import fdc_pkg::*;
#(
  parameter int UPD_CYC = UPD_CYCLES
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire fdc_axi_req_t axi_req,
  input wire fdc_axi_rsp_t axi_rsp,
  input wire logic [11:0]  analog_feedback_input,
  input wire logic [9:0]   motor_duty_mag,
  input wire logic         motor_dir,
  input wire logic         aux_power,
  input wire logic         irq
);
  logic [31:0] ph_q;
  // Period phase; mirrors the update counter so output moves can be placed
  always_ff @(posedge aclk) begin
    if (!aresetn || ph_q == UPD_CYC - 1) ph_q <= '0;
    else ph_q <= ph_q + 32'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  duty_bound_a: assert property (motor_duty_mag <= DUTY_FULL)
    else $error("duty magnitude above full scale");
  mag_hold_a: assert property ($changed(motor_duty_mag) |->
    ph_q inside {[1:29]}) else $error("duty moved between updates");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    motor_duty_mag == 10'h000 && aux_power && !irq)
    else $error("outputs not quiet in reset");
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("b dropped");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("r dropped");
  ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("arready while r pending");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid) else $error("read answer late");
  write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
    else $error("write answer late");
endmodule
bind fdc_duty_path fdc_duty_path_assertions #(.UPD_CYC(UPD_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .analog_feedback_input(analog_feedback_input),
  .motor_duty_mag(motor_duty_mag), .motor_dir(motor_dir),
  .aux_power(aux_power), .irq(irq));

// File: bench/fdc_fb_model.sv
// Position sensor model: pot wiper code seen at the feedback pin
`timescale 1ns/100ps
module fdc_fb_model (
  input  wire logic        aclk,
  input  wire logic        aux_power,
  input  wire logic [11:0] pos_code,
  output logic [11:0]      analog_feedback_input
);
  // Pot loses its supply while aux is low, so the wiper falls to 0 V
  always_ff @(posedge aclk) begin
    analog_feedback_input <= aux_power ? pos_code : 12'h000;
  end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the duty path
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import fdc_pkg::*;
  logic         aclk = 0, aresetn = 0;
  fdc_axi_req_t req = '0;
  fdc_axi_rsp_t rsp;
  logic [11:0]  pos = 12'h000, fb;
  logic [9:0]   mag;
  logic         dir, aux, irq, oor;
  logic [3:0]   strb = 4'hf;
  logic [31:0]  rd_d;
  logic [1:0]   resp;
  int fails = 0, n_checks = 0, seed = 72;
  int maxd = 600, acc = 600, prv = 0, t, mn, mx, pr, fi, mi, s, dct, dty;
  fdc_duty_path #(.UPD_CYC(200)) dut (.aclk(aclk), .aresetn(aresetn),
    .axi_req(req), .axi_rsp(rsp), .analog_feedback_input(fb),
    .motor_duty_mag(mag), .motor_dir(dir), .aux_power(aux), .irq(irq));
  fdc_fb_model u_fb (.aclk(aclk), .aux_power(aux), .pos_code(pos),
    .analog_feedback_input(fb));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_sim;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well above the expected run length
  initial begin
    repeat (80000) @(posedge aclk);
    fails++;
    end_sim();
  end
  // AXI write; AW and W released one by one as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1;
    req.wdata <= d; req.wstrb <= strb; req.bready <= 1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 0;
      if (req.wvalid && rsp.wready) req.wvalid <= 0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 0;
    end while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata; resp = rsp.rresp;
    req.rready <= 0;
  endtask
  // Clear both flags and poll for the next finished update
  task automatic wait_upd;
    wr(A_IRQSTS, 32'h3);
    do rd(A_IRQSTS); while (rd_d[I_UPDATE] !== 1'b1);
  endtask
  function automatic int scl(int r, int lo, int hi, int inv);
    int v;
    if (r > hi || (hi <= lo && r >= hi)) v = 4095;
    else if (r < lo) v = 0;
    else v = (r - lo) * 4095 / (hi - lo);
    return inv ? 4095 - v : v;
  endfunction
  function automatic int lim(int d);
    int v;
    v = d > maxd ? maxd : (d < -maxd ? -maxd : d);
    v = v > prv + acc ? prv + acc : (v < prv - acc ? prv - acc : v);
    return v;
  endfunction
  // Duty register, magnitude and direction after one update
  task automatic chk_duty(input int d, input int minv);
    dty = lim(d);
    prv = dty;
    rd(A_DCT);
    `CHK(rd_d, 32'(d))
    rd(A_DUTY);
    `CHK(rd_d, 32'(dty))
    `CHK(mag, 10'(dty < 0 ? -dty : dty))
    `CHK(dir, 1'((dty < 0) ^ minv))
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    // Reset values, refused and read-only places
    rd(A_TARGET);
    `CHK(rd_d, 32'h800)
    rd(A_FB_MAX);
    `CHK(rd_d, 32'hfff)
    rd(A_MAXDUT);
    `CHK(rd_d, 32'h258)
    rd(A_CTRL);
    `CHK(rd_d, 32'h0)
    rd(8'h38);
    `CHK(resp, RESP_SLVERR)
    // Misaligned write is refused and must leave the target alone
    wr(8'h05, 32'h1);
    `CHK(resp, RESP_SLVERR)
    rd(A_TARGET);
    `CHK(rd_d, 32'h800)
    wr(A_RAW, 32'h5);
    `CHK(resp, RESP_OKAY)
    rd(A_RAW);
    `CHK(rd_d, 32'h0)
    // One byte lane only: upper target bits must survive
    strb = 4'h1;
    wr(A_TARGET, 32'h0000_0f55);
    strb = 4'hf;
    rd(A_TARGET);
    `CHK(rd_d, 32'h855)
    wr(A_TARGET, 32'h800);
    wr(A_MAXDUT, 32'h2bc);
    rd(A_MAXDUT);
    `CHK(rd_d, 32'h258)
    // Config above lands well before the first tick
    wait_upd();
    chk_duty(0, 0);
    acc = 1023;
    wr(A_MAXACC, 32'h3ff);
    wr(A_IRQMSK, 32'h1);
    // Open loop: corners first, then random targets
    for (int i = 0; i < 14; i++) begin
      t = i == 0 ? 2048 : i == 1 ? 2648 : i == 2 ? 1448 : i == 3 ? 4095 :
          i == 4 ? 0 : 1448 + {$random(seed)} % 1201;
      mi = i[0];
      wr(A_TARGET, 32'(t));
      wr(A_CTRL, 32'(mi << C_MOT_INV));
      wait_upd();
      `CHK(irq, 1'b1)
      `CHK(rd_d[I_RANGE], 1'b0)
      chk_duty(t - 2048, mi);
    end
    wr(A_IRQSTS, 32'h1);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    // Closed loop with random scaling, inversion and gain
    for (int i = 0; i < 20; i++) begin
      mn = {$random(seed)} % 2000;
      mx = i == 0 ? mn : mn + 1 + {$random(seed)} % (4095 - mn);
      pos <= i == 1 ? 12'hfff : i == 2 ? 12'h000 : 12'($random(seed));
      fi = i[1];
      mi = i[2];
      pr = {$random(seed)} % 4;
      t = {$random(seed)} % 4096;
      wr(A_FB_MIN, 32'(mn));
      wr(A_FB_MAX, 32'(mx));
      wr(A_PROP, 32'(pr));
      wr(A_TARGET, 32'(t));
      wr(A_IRQMSK, 32'h0);
      wr(A_CTRL, 32'(1 | fi << C_FB_INV | mi << C_MOT_INV));
      wait_upd();
      // Out-of-range flag from the clamp conditions
      oor = pos > mx || pos < mn || (mx <= mn && pos >= mx);
      `CHK(rd_d[I_RANGE], oor)
      `CHK(irq, 1'b0)
      s = scl(pos, mn, mx, fi);
      rd(A_RAW);
      `CHK(rd_d, 32'(pos))
      rd(A_SCALED);
      `CHK(rd_d, 32'(s))
      rd(A_ERROR);
      `CHK(rd_d, 32'(s - t))
      chk_duty(-(s - t) * pr, mi);
    end
    // Step and duty limits in open loop
    wr(A_CTRL, 32'h0);
    wr(A_TARGET, 32'd2648);
    acc = 100;
    wr(A_MAXACC, 32'd100);
    maxd = 250;
    wr(A_MAXDUT, 32'd250);
    for (int i = 0; i < 5; i++) begin
      wait_upd();
      chk_duty(600, 0);
    end
    // Disconnect detect drives aux low
    wr(A_CTRL, 32'h1 << C_DET_EN);
    wait_upd();
    wait_upd();
    `CHK(aux, 1'b0)
    wr(A_CTRL, 32'h0);
    wait_upd();
    wait_upd();
    `CHK(aux, 1'b1)
    end_sim();
  end
endmodule
